// ### design/sffl_flag_ctrl.sv
`timescale 1ns/100ps

`include "sffl_regs.svh"

// Summary of operation
// RULE1 - program word low bits set almost offset
// RULE2 - unprogrammed offset defaults to sixteen
// RULE3 - program word top bits select parity
// RULE4 - unprogrammed parity stays disabled
// RULE5 - almost pin unavailable when depth cascaded
// RULE6 - three pins encode six fill states
// RULE7 - state boundaries follow offset and depth
// RULE8 - zero offset makes almost equal boundary
// RULE9 - empty side flags change on read edge
// RULE10 - full side flags change on write edge
// RULE11 - opposite clock changes wait for update
// RULE12 - skew window decides opposite operation inclusion
// RULE13 - latent read only clears empty indication
// RULE14 - latent read happens without read enable
// RULE15 - latent write only clears full indication
// RULE16 - latent write happens without write enable
// RULE17 - flags re-evaluated every owning clock cycle
// RULE18 - almost flag at or below offset
// RULE19 - boundary-programmed almost flag keeps update behaviour
// RULE20 - program read returns program register
// RULE21 - program write during master reset low
// RULE22 - master reset gives empty state
// RULE23 - enabled update cycle also moves count
// RULE24 - separate count views through synchroniser
// RULE25 - writes when full, reads when empty ignored
module sffl_flag_ctrl
	import sffl_pkg::*;
#(
	parameter int DEPTH = `SFFL_DEF_DEPTH	// Words: 512, 1024 or 2048
) (
	input  wire logic                     clk,			// System clock
	input  wire logic                     reset_n,		// Synchronous reset
	input  wire logic                     write_clk,		// Write clock pin
	input  wire logic                     read_clk,		// Read clock pin
	input  wire logic                     write_en_n,		// Write enable pin
	input  wire logic                     read_en_n,		// Read enable pin
	input  wire logic                     master_rst_n,	// Master reset pin
	input  wire logic                     cascaded,		// Depth cascade strap
	input  wire logic [`SFFL_DATA_W-1:0]  dataIn,			// Data pins
	output logic                          empty_full_n,	// Empty or full pin
	output logic                          almost_bound_n,	// Almost pin
	output logic                          half_full_n,	// Half full pin
	output logic                          writeStore,		// Store pulse
	output logic [$clog2(DEPTH)-1:0]      writeAddr,		// Store address
	output logic                          readTake,		// Fetch pulse
	output logic [$clog2(DEPTH)-1:0]      readAddr,		// Fetch address
	output sffl_parity_t                  parityMode,		// Parity option
	output logic [`SFFL_DATA_W-1:0]       progData,		// Program read word
	output logic                          progValid		// Program read pulse
);

	localparam int AW = $clog2(DEPTH);	// Address width
	localparam int PW = AW - 1;		// Offset width: 8, 9 or 10 bits

	// Whole state of the block
	typedef struct packed {
		sffl_mode_e              mode;		// Run or program mode
		logic                    wcPrev;		// Write clock last level
		logic                    rcPrev;		// Read clock last level
		logic [AW:0]             wp;			// Write pointer
		logic [AW:0]             rp;			// Read pointer
		logic [AW:0]             wpS1;		// Write pointer, stage one
		logic [AW:0]             wpS2;		// Write pointer seen by read side
		logic [AW:0]             rpS1;		// Read pointer, stage one
		logic [AW:0]             rpS2;		// Read pointer seen by write side
		logic                    rdEmpty;		// Empty held by read side
		logic                    rdAlmost;	// Almost empty held by read side
		logic                    wrFull;		// Full held by write side
		logic                    wrAlmost;	// Almost full held by write side
		logic                    wrHalf;		// Over half held by write side
		logic [PW-1:0]           offset;		// Almost offset
		sffl_parity_t            parity;		// Parity option
		logic                    pinEF;		// Empty or full pin level
		logic                    pinAB;		// Almost pin level
		logic                    pinHF;		// Half full pin level
		logic                    store;		// Store pulse
		logic [AW-1:0]           wAddr;		// Store address
		logic                    take;		// Fetch pulse
		logic [AW-1:0]           rAddr;		// Fetch address
		logic [`SFFL_DATA_W-1:0] pData;		// Program read word
		logic                    pValid;		// Program read pulse
	} sffl_state_s;

	sffl_state_s st_r;		// Registered state
	sffl_state_s st_nxt;	// Next state

	// Synchronised pins
	logic [5:0]              ctlS;		// Clocks, enables, reset, strap
	logic [`SFFL_DATA_W-1:0] dataS;		// Data pins
	logic                    wcS;		// Write clock level
	logic                    rcS;		// Read clock level
	logic                    wenS;		// Write enable, active low
	logic                    renS;		// Read enable, active low
	logic                    mrS;		// Master reset, active low
	logic                    cascS;		// Cascade strap

	// Edge and operation decode
	logic                    wrEdge;		// Write clock rising edge
	logic                    rdEdge;		// Read clock rising edge
	logic                    doWrite;		// Accepted write
	logic                    doRead;		// Accepted read
	logic [AW:0]             wrCountNxt;	// Write view after this edge
	logic [AW:0]             rdCountNxt;	// Read view after this edge
	logic [AW:0]             rdCount;		// Read view now

	// Zone decode outputs
	logic                    wzHalf;		// Over half, write view
	logic                    wzNearF;		// Almost full, write view
	logic                    wzFull;		// Full, write view
	logic                    rzEmpty;		// Empty, read view
	logic                    rzNearE;		// Almost empty, read view

	// Every pin from outside passes two flops first
	sffl_pin_sync #(
		.W (6)
	) u_ctl_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pinAsync ({cascaded, master_rst_n, read_en_n, write_en_n, read_clk, write_clk}),
		.pinSync  (ctlS)
	);

	sffl_pin_sync #(
		.W (`SFFL_DATA_W)
	) u_data_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pinAsync (dataIn),
		.pinSync  (dataS)
	);

	assign wcS   = ctlS[0];
	assign rcS   = ctlS[1];
	assign wenS  = ctlS[2];
	assign renS  = ctlS[3];
	assign mrS   = ctlS[4];
	assign cascS = ctlS[5];

	// Each side sees the other's pointer two cycles late, so an
	// opposite operation near the owning edge may fall either way,
	// while one well before it is always counted [RULE12] [RULE24]
	always_comb begin
		wrEdge     = wcS & ~st_r.wcPrev;
		rdEdge     = rcS & ~st_r.rcPrev;
		// A shown full or shown empty blocks the operation [RULE25]
		doWrite    = wrEdge & mrS & ~st_r.wrFull & ~wenS;
		doRead     = rdEdge & mrS & ~st_r.rdEmpty & ~renS;
		wrCountNxt = st_r.wp + (AW+1)'(doWrite) - st_r.rpS2;	// [RULE24]
		rdCount    = st_r.wpS2 - st_r.rp;	// [RULE24]
		rdCountNxt = rdCount - (AW+1)'(doRead);
	end

	// Write side zones, judged on its own view
	sffl_zone #(
		.AW (AW),
		.PW (PW)
	) u_wr_zone (
		.count     (wrCountNxt),
		.offset    (st_r.offset),
		.isEmpty   (),
		.nearEmpty (),
		.overHalf  (wzHalf),
		.nearFull  (wzNearF),
		.isFull    (wzFull)
	);

	// Read side zones, judged on its own view
	sffl_zone #(
		.AW (AW),
		.PW (PW)
	) u_rd_zone (
		.count     (rdCountNxt),
		.offset    (st_r.offset),
		.isEmpty   (rzEmpty),
		.nearEmpty (rzNearE),
		.overHalf  (),
		.nearFull  (),
		.isFull    ()
	);

	// Next state
	always_comb begin
		st_nxt        = st_r;
		st_nxt.store  = 1'b0;
		st_nxt.take   = 1'b0;
		st_nxt.pValid = 1'b0;
		st_nxt.wcPrev = wcS;
		st_nxt.rcPrev = rcS;
		st_nxt.wpS1   = st_r.wp;	// [RULE24]
		st_nxt.wpS2   = st_r.wpS1;
		st_nxt.rpS1   = st_r.rp;	// [RULE24]
		st_nxt.rpS2   = st_r.rpS1;

		// Mode follows the master reset pin
		case (st_r.mode)
			SFFL_PROG: begin
				if (mrS) begin
					st_nxt.mode = SFFL_RUN;
				end
			end
			SFFL_RUN: begin
				if (!mrS) begin
					st_nxt.mode = SFFL_PROG;
					// Falling edge restores the unprogrammed defaults
					st_nxt.offset = PW'(`SFFL_DEF_OFFSET);	// [RULE2]
					st_nxt.parity = `SFFL_DEF_PARITY;	// [RULE4]
				end
			end
			default: begin
				st_nxt.mode = SFFL_PROG;
			end
		endcase

		if (!mrS) begin
			// Master reset empties the buffer on both views [RULE22]
			st_nxt.wp       = '0;
			st_nxt.rp       = '0;
			st_nxt.wpS1     = '0;
			st_nxt.wpS2     = '0;
			st_nxt.rpS1     = '0;
			st_nxt.rpS2     = '0;
			st_nxt.rdEmpty  = 1'b1;
			st_nxt.rdAlmost = 1'b1;
			st_nxt.wrFull   = 1'b0;
			st_nxt.wrAlmost = 1'b0;
			st_nxt.wrHalf   = 1'b0;
			// Program write: write edge with enable low [RULE21]
			if (wrEdge && !wenS) begin
				st_nxt.offset = dataS[PW-1:0];	// [RULE1]
				st_nxt.parity = dataS[`SFFL_PAR_MSB:`SFFL_PAR_LSB];	// [RULE3]
			end
			// Program read: read edge with enable low [RULE20]
			if (rdEdge && !renS) begin
				st_nxt.pData = '0;
				st_nxt.pData[PW-1:0] = st_r.offset;
				st_nxt.pData[`SFFL_PAR_MSB:`SFFL_PAR_LSB] = st_r.parity;
				st_nxt.pValid = 1'b1;
			end
		end else begin
			// Outside master reset, full side flags move only here, once per write edge,
			// enabled or not; a shown full edge only refreshes
			// [RULE10] [RULE11] [RULE15] [RULE16] [RULE17] [RULE23]
			if (wrEdge) begin
				if (doWrite) begin
					st_nxt.wp    = st_r.wp + (AW+1)'(1);
					st_nxt.store = 1'b1;
					st_nxt.wAddr = st_r.wp[AW-1:0];
				end
				st_nxt.wrFull   = wzFull;
				st_nxt.wrAlmost = wzNearF;	// [RULE19]
				st_nxt.wrHalf   = wzHalf;
			end
			// Outside master reset, empty side flags move only here, once per read edge
			// [RULE9] [RULE11] [RULE13] [RULE14] [RULE17] [RULE23]
			if (rdEdge) begin
				if (doRead) begin
					st_nxt.rp    = st_r.rp + (AW+1)'(1);
					st_nxt.take  = 1'b1;
					st_nxt.rAddr = st_r.rp[AW-1:0];
				end
				st_nxt.rdEmpty  = rzEmpty;
				st_nxt.rdAlmost = rzNearE;	// [RULE19]
			end
		end

		// Pin encoding; the almost pin idles high when cascaded
		st_nxt.pinEF = ~(st_nxt.rdEmpty | st_nxt.wrFull);	// [RULE6]
		st_nxt.pinAB = cascS | ~(st_nxt.rdAlmost | st_nxt.wrAlmost);	// [RULE5] [RULE6]
		st_nxt.pinHF = ~st_nxt.wrHalf;	// [RULE6]
	end

	// State register; reset shows the empty encoding at once
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '{mode: SFFL_PROG, rdEmpty: 1'b1, rdAlmost: 1'b1,
				pinHF: 1'b1, offset: PW'(`SFFL_DEF_OFFSET),
				parity: `SFFL_DEF_PARITY, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign empty_full_n   = st_r.pinEF;
	assign almost_bound_n = st_r.pinAB;
	assign half_full_n    = st_r.pinHF;
	assign writeStore     = st_r.store;
	assign writeAddr      = st_r.wAddr;
	assign readTake       = st_r.take;
	assign readAddr       = st_r.rAddr;
	assign parityMode     = st_r.parity;
	assign progData       = st_r.pData;
	assign progValid      = st_r.pValid;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_reset_empty: assert property (!mrS |=> ##1 {empty_full_n, half_full_n} == 2'b01) // [RULE22]
		else $error("master reset did not show empty");

	// The almost pin idles high while cascaded, so only judge it when not
	a_pin_legal: assert property (!$past(cascS) |-> // [RULE6]
		{empty_full_n, almost_bound_n, half_full_n} != 3'b010
		&& {empty_full_n, almost_bound_n, half_full_n} != 3'b011)
		else $error("illegal flag pin combination");

	a_empty_readedge: assert property ($changed(st_r.rdEmpty) |-> // [RULE9]
		$past(rdEdge) || !$past(mrS))
		else $error("empty flag moved without read edge");

	a_full_writeedge: assert property ($changed(st_r.wrFull) |-> // [RULE10]
		$past(wrEdge) || !$past(mrS))
		else $error("full flag moved without write edge");

	a_full_blocks: assert property (mrS && wrEdge && st_r.wrFull |=> // [RULE15]
		st_r.wp == $past(st_r.wp) && !writeStore)
		else $error("write taken while full shown");

	a_empty_blocks: assert property (mrS && rdEdge && st_r.rdEmpty |=> // [RULE13]
		st_r.rp == $past(st_r.rp) && !readTake)
		else $error("read taken while empty shown");

	a_latent_clear: assert property (mrS && rdEdge && st_r.rdEmpty && rdCount != '0 |=> // [RULE14]
		empty_full_n)
		else $error("latent read cycle did not clear empty");

	// A program write in the very cycle of the falling edge wins
	a_default_offset: assert property (st_r.mode == SFFL_RUN && !mrS // [RULE2]
		&& !(wrEdge && !wenS) |=> st_r.offset == PW'(`SFFL_DEF_OFFSET)
		&& st_r.parity == `SFFL_DEF_PARITY)
		else $error("defaults not restored by master reset");

	a_run_store: assert property (mrS && wrEdge && !wenS && !st_r.wrFull |=> writeStore) // [RULE23]
		else $error("enabled write not stored");

	a_run_take: assert property (mrS && rdEdge && !renS && !st_r.rdEmpty |=> readTake) // [RULE23]
		else $error("enabled read not taken");

	a_prog_write: assert property (!mrS && wrEdge && !wenS |=> // [RULE21]
		st_r.offset == PW'($past(dataS)) && parityMode == 3'($past(dataS) >> `SFFL_PAR_LSB))
		else $error("program write not loaded");

	a_prog_read: assert property (!mrS && rdEdge && !renS |=> // [RULE20]
		progValid && progData[PW-1:0] == $past(st_r.offset))
		else $error("program read word wrong");

	a_full_pins: assert property (st_r.wrFull |-> !empty_full_n && !half_full_n) // [RULE6]
		else $error("full held but pins not full");

	a_cascade_off: assert property (cascS && $past(cascS) |=> almost_bound_n) // [RULE5]
		else $error("almost pin active while cascaded");

endmodule

// ### design/sffl_pin_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a group of asynchronous pins.
// The first stage is read by the second stage only.
module sffl_pin_sync #(
	parameter int W = 1	// Number of pins in the group
) (
	input  wire logic         clk,		// System clock
	input  wire logic         reset_n,	// Synchronous reset, active low
	input  wire logic [W-1:0] pinAsync,	// Raw pin levels
	output logic      [W-1:0] pinSync	// Levels after two flops
);

	logic [W-1:0] meta_r;	// First stage, may go metastable

	// Both stages clear on reset so the block starts in master reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_r  <= '0;
			pinSync <= '0;
		end else begin
			meta_r  <= pinAsync;
			pinSync <= meta_r;
		end
	end

endmodule

// ### design/sffl_pkg.sv
package sffl_pkg;

	// Operating mode, one-hot coded
	typedef enum logic [1:0] {
		SFFL_PROG = 2'b01,	// Master reset held, program port open
		SFFL_RUN  = 2'b10	// Normal buffer operation
	} sffl_mode_e;

	// Parity option as loaded from the program word
	typedef logic [2:0] sffl_parity_t;

endpackage

// ### design/sffl_regs.svh
`ifndef SFFL_REGS_SVH
`define SFFL_REGS_SVH

// Width of the data pins that carry the program word
`define SFFL_DATA_W      18
// Parity option field on the program word
`define SFFL_PAR_LSB     15
`define SFFL_PAR_MSB     17
// Values restored by each falling edge of master reset
`define SFFL_DEF_OFFSET  10'h010
`define SFFL_DEF_PARITY  3'h0
// Default number of words in the buffer
`define SFFL_DEF_DEPTH   2048

`endif

// ### design/sffl_zone.sv
`timescale 1ns/100ps

// Decodes a word count against the almost offset into fill zones.
module sffl_zone #(
	parameter int AW = 11,	// Address width, depth is 2**AW
	parameter int PW = 10	// Offset width
) (
	input  wire logic [AW:0]   count,		// Words held
	input  wire logic [PW-1:0] offset,		// Almost offset
	output logic               isEmpty,		// No word held
	output logic               nearEmpty,	// Words at or below offset
	output logic               overHalf,	// More than half held
	output logic               nearFull,	// Free places at or below offset
	output logic               isFull		// Every place held
);

	localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);	// Capacity
	localparam logic [AW:0] HALF  = (AW+1)'(2**(AW-1));	// Half capacity

	logic [AW:0] freeCnt;	// Free places
	logic [AW:0] offWide;	// Offset at count width

	// Zero offset collapses the almost zones onto empty and full [RULE8]
	always_comb begin
		offWide   = (AW+1)'(offset);
		freeCnt   = DEPTH - count;
		isEmpty   = (count == '0);
		isFull    = (count == DEPTH);
		nearEmpty = (count <= offWide);	// [RULE7] [RULE18]
		nearFull  = (freeCnt <= offWide);	// [RULE7] [RULE18]
		overHalf  = (count > HALF);	// [RULE7]
	end

endmodule

// ### verification/sffl_far_end.sv
`timescale 1ns/100ps

// Far-side system logic: frames the pin clocks and drives enables and data
module sffl_far_end (
	input  wire logic        clk,			// System clock, pins change at its fall
	output logic             write_clk,		// Write clock pin, still outside frames
	output logic             read_clk,		// Read clock pin, still outside frames
	output logic             write_en_n,		// Write enable pin
	output logic             read_en_n,		// Read enable pin
	output logic             master_rst_n,	// Master reset pin
	output logic [17:0]      dataIn			// Data pins
);
	// Power-up holds master reset so the first cycle is a program cycle
	initial begin
		write_clk    = 1'b0;
		read_clk     = 1'b0;
		write_en_n   = 1'b1;
		read_en_n    = 1'b1;
		master_rst_n = 1'b0;
		dataIn       = 18'h2aaaa;
	end

	// One clock frame; each phase spans three system cycles to beat the synchroniser
	task automatic pulse(input int isWr, input int en, input logic [17:0] d);
		@(negedge clk);
		if (isWr) begin
			write_en_n = !en;
			dataIn     = d;
		end else begin
			read_en_n = !en;
		end
		repeat (3) @(negedge clk);
		if (isWr) write_clk = 1'b1;
		else read_clk = 1'b1;
		repeat (3) @(negedge clk);
		write_clk = 1'b0;
		read_clk  = 1'b0;
		repeat (3) @(negedge clk);
		// Released data never keeps the old value, so stale reads show up
		write_en_n = 1'b1;
		read_en_n  = 1'b1;
		dataIn     = ~d;
	endtask

	// Master reset level change, then time for the synchroniser
	task automatic mrst(input int lvl);
		@(negedge clk);
		master_rst_n = (lvl != 0);
		repeat (6) @(negedge clk);
	endtask
endmodule

// ### verification/tb_sync_fifo_flag_and_program_logic.sv
`timescale 1ns/100ps

// Self-checking bench for the flag and program logic at 512 words
module tb_sync_fifo_flag_and_program_logic
	import sffl_pkg::*;
;
	localparam int D = 512;		// Smallest depth keeps the fill loop short

	logic               clk;		// System clock
	logic               reset_n;	// Synchronous reset
	logic               cascaded;	// Depth cascade strap
	logic               write_clk;	// Pin clocks and enables from far side
	logic               read_clk;
	logic               write_en_n;
	logic               read_en_n;
	logic               master_rst_n;
	logic [17:0]        dataIn;
	logic               empty_full_n;	// Flag pins
	logic               almost_bound_n;
	logic               half_full_n;
	logic               writeStore;
	logic               readTake;
	logic [8:0]         writeAddr;	// Store address, 512 words
	logic [8:0]         readAddr;	// Fetch address, 512 words
	sffl_parity_t       parityMode;
	logic [17:0]        progData;
	logic               progValid;
	logic [2:0]         pins;		// Flag pins as one word
	logic [17:0]        progSeen;	// Last program read word
	int                 nWr;		// Store pulses seen
	int                 nRd;		// Fetch pulses seen
	int                 cnt;		// Words held by our own count
	int                 errors;
	int                 check_count;

	assign pins = {empty_full_n, almost_bound_n, half_full_n};

	sffl_far_end u_far (
		.clk          (clk),
		.write_clk    (write_clk),
		.read_clk     (read_clk),
		.write_en_n   (write_en_n),
		.read_en_n    (read_en_n),
		.master_rst_n (master_rst_n),
		.dataIn       (dataIn)
	);

	sffl_flag_ctrl #(.DEPTH(D)) u_dut (
		.clk            (clk),
		.reset_n        (reset_n),
		.write_clk      (write_clk),
		.read_clk       (read_clk),
		.write_en_n     (write_en_n),
		.read_en_n      (read_en_n),
		.master_rst_n   (master_rst_n),
		.cascaded       (cascaded),
		.dataIn         (dataIn),
		.empty_full_n   (empty_full_n),
		.almost_bound_n (almost_bound_n),
		.half_full_n    (half_full_n),
		.writeStore     (writeStore),
		.writeAddr      (writeAddr),
		.readTake       (readTake),
		.readAddr       (readAddr),
		.parityMode     (parityMode),
		.progData       (progData),
		.progValid      (progValid)
	);

	// Clock generator
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// Counts one-cycle pulses so refused operations show as no change;
	// sampled at the falling edge, where the outputs have settled
	always @(negedge clk) begin
		if (writeStore === 1'b1) nWr++;
		if (readTake === 1'b1) nRd++;
		if (progValid === 1'b1) progSeen <= progData;
	end

	// Expected pin word for a count and offset
	function automatic logic [2:0] enc(input int n, input int p);
		if (n == 0) return 3'h1;
		if (n <= p) return 3'h5;
		if (n <= D / 2) return 3'h7;
		if (n <= D - 1 - p) return 3'h6;
		if (n < D) return 3'h4;
		return 3'h0;
	endfunction

	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Defaults after power-up, before any program write
	task automatic t_defaults();
		chk(18'(pins), 18'h1);
		chk(18'(parityMode), 18'h0);
		u_far.pulse(0, 1, 18'h0);
		chk(progSeen, 18'h00010);
		u_far.mrst(1);
	endtask

	// One word into empty: latent read, cascade, then reads
	task automatic t_empty();
		int w0;
		int r0;
		w0 = nWr;
		r0 = nRd;
		u_far.pulse(1, 1, 18'h1234);
		chk(18'(pins), 18'h1);
		chk(18'(writeAddr), 18'h0);
		u_far.pulse(0, 0, 18'h0);
		chk(18'(pins), 18'h5);
		chk(18'(nRd - r0), 18'h0);
		cascaded = 1'b1;
		repeat (6) @(negedge clk);
		chk(18'(almost_bound_n), 18'h1);
		cascaded = 1'b0;
		repeat (6) @(negedge clk);
		u_far.pulse(0, 1, 18'h0);
		chk(18'(pins), 18'h1);
		chk(18'(readAddr), 18'h0);
		u_far.pulse(0, 1, 18'h0);
		chk(18'(nRd - r0), 18'h1);
		chk(18'(nWr - w0), 18'h1);
	endtask

	// Fill to full checking every state, then refusal and latent write
	task automatic t_fill();
		int w0;
		cnt = 0;
		for (int i = 1; i <= 17; i++) begin
			u_far.pulse(1, 1, 18'(i));
			cnt++;
			if (i == 16) begin
				u_far.pulse(0, 0, 18'h0);
				chk(18'(pins), 18'(enc(cnt, 16)));
			end
		end
		u_far.pulse(0, 0, 18'h0);
		chk(18'(pins), 18'h7);
		while (cnt < D) begin
			u_far.pulse(1, 1, 18'(cnt));
			cnt++;
			chk(18'(pins), 18'(enc(cnt, 16)));
		end
		w0 = nWr;
		u_far.pulse(1, 1, 18'h3ffff);
		chk(18'(nWr - w0), 18'h0);
		u_far.pulse(0, 1, 18'h0);
		chk(18'(pins), 18'h0);
		chk(18'(readAddr), 18'h1);
		u_far.pulse(1, 0, 18'h0);
		chk(18'(pins), 18'h4);
		chk(18'(nWr - w0), 18'h0);
	endtask

	// Zero offset with parity loaded, then master reset restores defaults
	task automatic t_program();
		u_far.mrst(0);
		chk(18'(pins), 18'h1);
		u_far.pulse(1, 1, 18'h28000);
		chk(18'(parityMode), 18'h5);
		u_far.pulse(0, 1, 18'h0);
		chk(progSeen, 18'h28000);
		u_far.mrst(1);
		u_far.pulse(1, 1, 18'h00055);
		chk(18'(writeAddr), 18'h0);
		u_far.pulse(0, 0, 18'h0);
		chk(18'(pins), 18'h7);
		u_far.mrst(0);
		chk(18'(pins), 18'h1);
		chk(18'(parityMode), 18'h0);
	endtask

	// Main sequence
	initial begin
		reset_n     = 1'b0;
		cascaded    = 1'b0;
		progSeen    = 18'h0;
		nWr         = 0;
		nRd         = 0;
		errors      = 0;
		check_count = 0;
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		t_defaults();
		t_empty();
		t_fill();
		t_program();
		end_sim();
	end

	// Watchdog cuts a hang short
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule
